// file: pkg/rdsr_pkg.sv
// ======================================================
// receive readout constants
package rdsr_pkg;
   // ======================================================
   // bus geometry
   localparam int ADR_W = 12;
   localparam int DAT_W = 32;
   // register indices, byte address is four times the index
   localparam logic [ADR_W-1:0] REG_DATA_IDX = 12'h078;
   localparam logic [ADR_W-1:0] REG_STAT_IDX = 12'h07A;
   localparam logic [ADR_W-1:0] ADDR_DATA = 12'h1E0;
   localparam logic [ADR_W-1:0] ADDR_STAT = 12'h1E8;
   // local control, special character and fill level registers
   localparam logic [ADR_W-1:0] ADDR_CTRL = 12'h200;
   localparam logic [ADR_W-1:0] ADDR_SPEC = 12'h204;
   localparam logic [ADR_W-1:0] ADDR_LEVEL = 12'h208;
   localparam logic [DAT_W-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [DAT_W-1:0] SPEC_RST = 32'h0000_0000;
   localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;
   // control fields
   localparam int CTL_ARM = 0;
   localparam int CTL_SEQ = 1;
   localparam int CTL_PAR_LO = 4;
   localparam int CTL_PAR_HI = 5;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam int LVL_HOLD_BIT = 8;
   // ======================================================
   // status entry layout: status in the high byte, data in the low byte
   localparam int ENT_W = 16;
   localparam int ST_LO = 8;
   localparam int ST_TIMEOUT = 7;
   localparam int ST_SC_HI = 6;
   localparam int ST_SC_LO = 4;
   localparam int ST_BREAK = 3;
   localparam int ST_PARITY = 2;
   localparam int ST_FRAME = 1;
   localparam int ST_OVERRUN = 0;
   localparam logic [2:0] SC_NONE = 3'h0;
   localparam logic [2:0] SC_ONE = 3'h1;
   localparam logic [2:0] SC_TWO = 3'h2;
   localparam logic [2:0] SC_THREE = 3'h3;
   localparam logic [7:0] ST_TIMEOUT_VAL = 8'h80;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // ======================================================
   // depth and timing
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMEOUT_NS = 10000;
   localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
   // time-out watcher states
   typedef enum logic [1:0] {TO_IDLE, TO_COUNT, TO_DONE} rdsr_to_e;
endpackage

// file: logic/rdsr_entry_mem.sv
`timescale 1ns/1ps
// ======================================================
// entry store with registered read and write-through
module rdsr_entry_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // the address width must reach every entry
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_aw
      $error("address width too small for depth");
   end

   // write port
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // forwarding keeps a fresh write visible on the next read
   always_ff @(posedge clk) begin
      if (we && waddr == raddr) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// file: logic/rdsr_readout.sv
`timescale 1ns/1ps
// ======================================================
// receive data and character status readout
// Overview of operation
// - data read returns next FIFO byte
// - data read pops data and status together
// - bit 7 flags empty FIFO time-out
// - time-out entry carries no character
// - time-out only when armed by enable
// - bits 6:4 give special match code
// - bit 2 flags parity mismatch
// - bit 1 flags zero stop bit, except on break
// - overrun drops char, flags last stored
// - all zero character marks break
// - ones with zero stop: framing
// - odd parity zero: break and parity
// - several error flags may coexist
// - overrun flag independent of others
module rdsr_readout #(
   parameter int DEPTH = rdsr_pkg::FIFO_DEPTH,
   parameter int TO_CYC = rdsr_pkg::TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rdsr_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [rdsr_pkg::DAT_W-1:0] wb_dat_i,
   output logic [rdsr_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char_data,
   input wire logic rx_parity_bit,
   input wire logic rx_stop_bit
);
   localparam int AW = $clog2(DEPTH);
   localparam int TO_W = $clog2(TO_CYC + 1);

   // ======================================================
   // elaboration checks
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be a power of two, at least two");
   end
   if (TO_CYC < 1) begin : g_bad_timeout
      $error("time-out must be at least one cycle");
   end

   logic [rdsr_pkg::DAT_W-1:0] ctrl_reg;
   logic [rdsr_pkg::DAT_W-1:0] spec_reg;
   logic [AW:0] wptr_reg;
   logic [AW:0] rptr_reg;
   logic [AW:0] count;
   logic fifo_full;
   logic fifo_empty;
   logic hold_valid_reg;
   logic [rdsr_pkg::ENT_W-1:0] hold_entry_reg;
   logic [7:0] prev_char_reg;
   logic prev_valid_reg;
   logic [rdsr_pkg::ENT_W-1:0] rd_entry;
   logic [rdsr_pkg::ENT_W-1:0] push_entry;
   logic push_en;
   logic drain;
   logic to_fire;
   logic bus_req;
   logic pop;
   logic [rdsr_pkg::DAT_W-1:0] rd_value;
   logic [1:0] par_mode;
   logic par_err;
   logic brk;
   logic frame;
   logic [2:0] sc_code;
   logic [7:0] new_status;
   logic [7:0] sc1;
   logic [7:0] sc2;
   logic [7:0] sc3;
   logic [7:0] sc4;
   rdsr_pkg::rdsr_to_e to_state_reg;
   logic [TO_W-1:0] to_cnt_reg;

   // ======================================================
   // bus decode
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign pop = bus_req && !wb_we_i && wb_adr_i == rdsr_pkg::ADDR_DATA && !fifo_empty;
   assign count = wptr_reg - rptr_reg;
   assign fifo_full = count == (AW + 1)'(DEPTH);
   assign fifo_empty = count == '0;

   // answer every access one cycle after it is presented
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // read mux; writes to the readout registers are simply acknowledged
   always_comb begin
      rd_value = rdsr_pkg::READ_ZERO;
      unique case (wb_adr_i)
         rdsr_pkg::ADDR_DATA: begin
            if (!fifo_empty) begin
               rd_value[7:0] = rd_entry[7:0];
            end
         end
         rdsr_pkg::ADDR_STAT: begin
            if (!fifo_empty) begin
               rd_value[7:0] = rd_entry[rdsr_pkg::ENT_W-1:rdsr_pkg::ST_LO];
            end
         end
         rdsr_pkg::ADDR_CTRL: rd_value = ctrl_reg;
         rdsr_pkg::ADDR_SPEC: rd_value = spec_reg;
         rdsr_pkg::ADDR_LEVEL: begin
            rd_value[AW:0] = count;
            rd_value[rdsr_pkg::LVL_HOLD_BIT] = hold_valid_reg;
         end
         default: rd_value = rdsr_pkg::READ_ZERO;
      endcase
   end

   // read data register, zero after reset, holds the last read value between reads
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wb_dat_o <= rdsr_pkg::READ_ZERO;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= rd_value;
      end
   end

   // control registers with byte lanes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_reg <= rdsr_pkg::CTRL_RST;
         spec_reg <= rdsr_pkg::SPEC_RST;
      end else if (bus_req && wb_we_i) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b] && wb_adr_i == rdsr_pkg::ADDR_CTRL) begin
               ctrl_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            if (wb_sel_i[b] && wb_adr_i == rdsr_pkg::ADDR_SPEC) begin
               spec_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
      end
   end

   // ======================================================
   // character classification
   assign par_mode = ctrl_reg[rdsr_pkg::CTL_PAR_HI:rdsr_pkg::CTL_PAR_LO];
   assign sc1 = spec_reg[7:0];
   assign sc2 = spec_reg[15:8];
   assign sc3 = spec_reg[23:16];
   assign sc4 = spec_reg[31:24];

   // parity looks at its own bits, so it stacks with break or framing; framing excludes break
   always_comb begin
      par_err = (par_mode == rdsr_pkg::PAR_EVEN && ^{rx_char_data, rx_parity_bit})
         || (par_mode == rdsr_pkg::PAR_ODD && !(^{rx_char_data, rx_parity_bit}));
      brk = !rx_stop_bit && rx_char_data == rdsr_pkg::ZERO_BYTE
         && (par_mode == rdsr_pkg::PAR_NONE || !rx_parity_bit);
      frame = !rx_stop_bit && !brk;
   end

   // matching is skipped on any error so a damaged byte never triggers
   always_comb begin
      sc_code = rdsr_pkg::SC_NONE;
      if (!(par_err || brk || frame)) begin
         if (ctrl_reg[rdsr_pkg::CTL_SEQ]) begin
            if (prev_valid_reg && prev_char_reg == sc1 && rx_char_data == sc3) begin
               sc_code = rdsr_pkg::SC_ONE;
            end else if (prev_valid_reg && prev_char_reg == sc2 && rx_char_data == sc4) begin
               sc_code = rdsr_pkg::SC_TWO;
            end
         end else if (rx_char_data == sc1) begin
            sc_code = rdsr_pkg::SC_ONE;
         end else if (rx_char_data == sc2) begin
            sc_code = rdsr_pkg::SC_TWO;
         end else if (rx_char_data == sc3) begin
            sc_code = rdsr_pkg::SC_THREE;
         end
      end
   end

   assign new_status = {1'b0, sc_code, brk, par_err, frame, 1'b0};

   // previous character for sequence matching
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prev_char_reg <= rdsr_pkg::ZERO_BYTE;
         prev_valid_reg <= 1'b0;
      end else if (rx_char_valid) begin
         prev_char_reg <= rx_char_data;
         prev_valid_reg <= 1'b1;
      end
   end

   // ======================================================
   // holding register in front of the FIFO
   assign drain = hold_valid_reg && !fifo_full;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hold_valid_reg <= 1'b0;
         hold_entry_reg <= '0;
      end else if (rx_char_valid && (!hold_valid_reg || drain)) begin
         hold_valid_reg <= 1'b1;
         hold_entry_reg <= {new_status, rx_char_data};
      end else if (rx_char_valid) begin
         hold_entry_reg[rdsr_pkg::ST_LO + rdsr_pkg::ST_OVERRUN] <= 1'b1;
      end else if (drain) begin
         hold_valid_reg <= 1'b0;
      end
   end

   // ======================================================
   // time-out watcher, counts idle cycles while nothing is buffered
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         to_state_reg <= rdsr_pkg::TO_IDLE;
         to_cnt_reg <= '0;
      end else if (rx_char_valid) begin
         to_state_reg <= rdsr_pkg::TO_IDLE;
         to_cnt_reg <= '0;
      end else begin
         unique case (to_state_reg)
            rdsr_pkg::TO_IDLE: begin
               to_cnt_reg <= '0;
               if (ctrl_reg[rdsr_pkg::CTL_ARM] && fifo_empty && !hold_valid_reg) begin
                  to_state_reg <= rdsr_pkg::TO_COUNT;
               end
            end
            rdsr_pkg::TO_COUNT: begin
               if (!ctrl_reg[rdsr_pkg::CTL_ARM] || !fifo_empty || hold_valid_reg) begin
                  to_state_reg <= rdsr_pkg::TO_IDLE;
               end else if (to_fire) begin
                  to_state_reg <= rdsr_pkg::TO_DONE;
               end else begin
                  to_cnt_reg <= to_cnt_reg + 1'b1;
               end
            end
            rdsr_pkg::TO_DONE: begin
               to_cnt_reg <= '0;
            end
         endcase
      end
   end

   // one report per silence; a new character rearms it
   // empty time-out
   assign to_fire = to_state_reg == rdsr_pkg::TO_COUNT && ctrl_reg[rdsr_pkg::CTL_ARM]
      && fifo_empty && !hold_valid_reg && to_cnt_reg == TO_W'(TO_CYC - 1);

   // ======================================================
   // FIFO pointers and entry store
   // no data character
   assign push_entry = to_fire ? {rdsr_pkg::ST_TIMEOUT_VAL, rdsr_pkg::ZERO_BYTE}
      : hold_entry_reg;
   assign push_en = drain || to_fire;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wptr_reg <= '0;
      end else if (push_en) begin
         wptr_reg <= wptr_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rptr_reg <= '0;
      end else if (pop) begin
         rptr_reg <= rptr_reg + 1'b1;
      end
   end

   rdsr_entry_mem #(.WIDTH(rdsr_pkg::ENT_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(ref_clk),
      .we(push_en),
      .waddr(wptr_reg[AW-1:0]),
      .wdata(push_entry),
      .raddr(rptr_reg[AW-1:0]),
      .rdata(rd_entry)
   );

   // ======================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   sequence s_data_req;
      bus_req && !wb_we_i && wb_adr_i == rdsr_pkg::ADDR_DATA && !fifo_empty;
   endsequence
   sequence s_stat_req;
      bus_req && !wb_we_i && wb_adr_i == rdsr_pkg::ADDR_STAT;
   endsequence
   property p_data_pop;
      s_data_req |=> wb_ack_o && rptr_reg == $past(rptr_reg) + 1'b1;
   endproperty
   a_data_pop: assert property (p_data_pop) else $error("data read did not pop");
   property p_data_byte;
      s_data_req |=> wb_dat_o[7:0] == $past(rd_entry[7:0]) && wb_dat_o[31:8] == '0;
   endproperty
   a_data_byte: assert property (p_data_byte) else $error("data read wrong byte");
   property p_stat_hold;
      s_stat_req ##1 !pop |-> ##1 rptr_reg == $past(rptr_reg, 2);
   endproperty
   a_stat_hold: assert property (p_stat_hold) else $error("status read moved pointer");
   // the entry must come out of the store, not just leave the mux
   property p_timeout_entry;
      to_fire |=> rd_entry == {rdsr_pkg::ST_TIMEOUT_VAL, rdsr_pkg::ZERO_BYTE} && !fifo_empty;
   endproperty
   a_timeout_entry: assert property (p_timeout_entry) else $error("bad time-out entry");
   property p_timeout_arm;
      to_fire |-> ctrl_reg[rdsr_pkg::CTL_ARM] && $past(to_state_reg) != rdsr_pkg::TO_IDLE;
   endproperty
   a_timeout_arm: assert property (p_timeout_arm) else $error("time-out while unarmed");
   property p_break;
      rx_char_valid && !hold_valid_reg && !rx_stop_bit && rx_char_data == 8'h00
         && par_mode == rdsr_pkg::PAR_NONE |=> hold_entry_reg[11] && !hold_entry_reg[9];
   endproperty
   a_break: assert property (p_break) else $error("break not marked");
   property p_frame;
      rx_char_valid && !hold_valid_reg && !rx_stop_bit && rx_char_data != 8'h00
         |=> hold_entry_reg[9] && !hold_entry_reg[11];
   endproperty
   a_frame: assert property (p_frame) else $error("framing misclassified");
   property p_odd_zero;
      rx_char_valid && !hold_valid_reg && !rx_stop_bit && !rx_parity_bit
         && rx_char_data == 8'h00 && par_mode == rdsr_pkg::PAR_ODD
         |=> hold_entry_reg[11] && hold_entry_reg[10];
   endproperty
   a_odd_zero: assert property (p_odd_zero) else $error("odd zero not break and parity");
   property p_overrun;
      rx_char_valid && hold_valid_reg && fifo_full && !pop
         |=> hold_entry_reg[8] && hold_entry_reg[7:0] == $past(hold_entry_reg[7:0]);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");
   property p_sc_three;
      rx_char_valid && !hold_valid_reg && rx_stop_bit && par_mode == rdsr_pkg::PAR_NONE
         && !ctrl_reg[1] && rx_char_data == sc3 && rx_char_data != sc1
         && rx_char_data != sc2 |=> hold_entry_reg[14:12] == 3'h3;
   endproperty
   a_sc_three: assert property (p_sc_three) else $error("special code wrong");
endmodule

// file: dv/rdsr_host.sv
`timescale 1ns/1ps
// ======================================================
// host model: classic single wishbone cycles, one at a time
module rdsr_host #(
   parameter logic [rdsr_pkg::ADR_W-1:0] EOS_ADDR = 12'h1FC
) (
   input wire logic ref_clk,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [rdsr_pkg::ADR_W-1:0] adr,
   output logic [3:0] sel,
   output logic [rdsr_pkg::DAT_W-1:0] dat_o,
   input wire logic [rdsr_pkg::DAT_W-1:0] dat_i,
   input wire logic ack
);
   logic hung;
   // idle bus at time zero
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = '0;
      sel = 4'h0;
      dat_o = '0;
      hung = 1'b0;
   end
   // one bus cycle; ack and read data are both taken at the rising edge that shows ack
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= w ? 4'hF : 4'h0;
      dat_o <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      hung = hung | (ack !== 1'b1);
      q = dat_i;
      // release at the very edge that saw ack, never later
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      dat_o <= ~d; // released data no longer shows the old value
   endtask
   // status before data
   // the data read pops the shared status and data entry, so status has to come first
   task automatic take_entry(output logic [31:0] st, output logic [31:0] d);
      xfer(1'b0, rdsr_pkg::ADDR_STAT, 32'h0, st);
      xfer(1'b0, rdsr_pkg::ADDR_DATA, 32'h0, d);
   endtask
   // no readout writes
   // the only writes go to control places and this closing dummy write
   task automatic service_end();
      logic [31:0] q;
      xfer(1'b1, EOS_ADDR, 32'h0, q);
   endtask
endmodule

// file: dv/test_rx_data_status_readout.sv
`timescale 1ns/1ps
// ======================================================
// readout bench: table of single characters, then awkward cases
module test_rx_data_status_readout;
   localparam int TO = 8;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] data;
      logic par;
      logic stop;
      logic [7:0] st;
   } rdsr_row_s;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic cyc, stb, we, ack;
   logic [3:0] sel;
   logic [11:0] adr;
   logic [31:0] wdat, rdat;
   logic rx_char_valid = 1'b0;
   logic [7:0] rx_char_data = 8'h00;
   logic rx_parity_bit = 1'b0;
   logic rx_stop_bit = 1'b1;
   int n_mismatch = 0;
   int checks_done = 0;
   rdsr_row_s rows [12];
   logic [11:0] radr [6];
   always #5 ref_clk = ~ref_clk;
   rdsr_readout #(.TO_CYC(TO)) u_dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_char_valid(rx_char_valid),
      .rx_char_data(rx_char_data), .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit));
   rdsr_host u_host (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .dat_o(wdat), .dat_i(rdat), .ack(ack));
   // ======================================================
   // verdict and comparison
   task automatic results();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // a hung bus cycle ends the run through the verdict
   task automatic guard();
      if (u_host.hung) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      u_host.xfer(1'b0, a, 32'h0, q);
      guard();
      chk(q, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_host.xfer(1'b1, a, d, q);
      guard();
   endtask
   task automatic ent(input logic [7:0] est, input logic [7:0] ed);
      logic [31:0] st, d;
      u_host.take_entry(st, d);
      guard();
      chk(st, {24'h0, est});
      chk(d, {24'h0, ed});
   endtask
   // one character, then time for it to reach the fifo
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      @(posedge ref_clk);
      rx_char_valid <= 1'b1;
      rx_char_data <= d;
      rx_parity_bit <= p;
      rx_stop_bit <= s;
      @(posedge ref_clk);
      rx_char_valid <= 1'b0;
      rx_char_data <= ~d;
      repeat (3) @(posedge ref_clk);
   endtask
   // ======================================================
   // main sequence
   initial begin
      rows = '{'{8'h00, 8'h41, 1'b0, 1'b1, 8'h00}, '{8'h10, 8'h03, 1'b1, 1'b1, 8'h04},
               '{8'h10, 8'h07, 1'b1, 1'b1, 8'h00}, '{8'h20, 8'h01, 1'b0, 1'b1, 8'h00},
               '{8'h00, 8'h55, 1'b0, 1'b0, 8'h02}, '{8'h00, 8'h00, 1'b0, 1'b0, 8'h08},
               '{8'h20, 8'h00, 1'b0, 1'b0, 8'h0C}, '{8'h10, 8'h07, 1'b0, 1'b0, 8'h06},
               '{8'h00, 8'h11, 1'b0, 1'b1, 8'h10}, '{8'h00, 8'h22, 1'b0, 1'b1, 8'h20},
               '{8'h00, 8'h33, 1'b0, 1'b1, 8'h30}, '{8'h30, 8'h41, 1'b1, 1'b1, 8'h00}};
      radr = '{12'h1E0, 12'h1E8, 12'h200, 12'h204, 12'h208, 12'h1FC};
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      // every place reads zero after reset, unmapped one included
      for (int i = 0; i < 6; i++) begin
         rdc(radr[i], 32'h0);
      end
      wr(rdsr_pkg::ADDR_SPEC, 32'h4433_2211);
      // table: parity modes, errors, break, special codes
      for (int i = 0; i < 12; i++) begin
         wr(rdsr_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl});
         send(rows[i].data, rows[i].par, rows[i].stop);
         rdc(rdsr_pkg::ADDR_STAT, {24'h0, rows[i].st});
         ent(rows[i].st, rows[i].data);
         rdc(rdsr_pkg::ADDR_LEVEL, 32'h0);
         u_host.service_end();
      end
      // sequence match: first bytes read on the clean path, seconds carry codes one and two
      wr(rdsr_pkg::ADDR_CTRL, 32'h0000_0002);
      send(8'h11, 1'b0, 1'b1);
      send(8'h33, 1'b0, 1'b1);
      send(8'h22, 1'b0, 1'b1);
      send(8'h44, 1'b0, 1'b1);
      rdc(rdsr_pkg::ADDR_DATA, 32'h0000_0011);
      ent(8'h10, 8'h33);
      rdc(rdsr_pkg::ADDR_DATA, 32'h0000_0022);
      ent(8'h20, 8'h44);
      wr(rdsr_pkg::ADDR_CTRL, 32'h0);
      // burst every cycle: eight in fifo, one held, the tenth lost
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         rx_char_valid <= 1'b1;
         rx_char_data <= 8'(8'h60 + i);
         rx_stop_bit <= (i != 8);
      end
      @(posedge ref_clk);
      rx_char_valid <= 1'b0;
      rx_stop_bit <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(rdsr_pkg::ADDR_LEVEL, 32'h0000_0108);
      for (int i = 0; i < 9; i++) begin
         ent((i == 8) ? 8'h03 : 8'h00, 8'(8'h60 + i));
      end
      rdc(rdsr_pkg::ADDR_DATA, 32'h0);
      // idle while disarmed gives no entry, armed gives exactly one
      repeat (3 * TO + 6) @(posedge ref_clk);
      rdc(rdsr_pkg::ADDR_LEVEL, 32'h0);
      wr(rdsr_pkg::ADDR_CTRL, 32'h0000_0001);
      repeat (3 * TO + 6) @(posedge ref_clk);
      ent(8'h80, 8'h00);
      repeat (3 * TO + 6) @(posedge ref_clk);
      rdc(rdsr_pkg::ADDR_LEVEL, 32'h0);
      // reset in mid-run empties the store and disarms
      send(8'h5A, 1'b0, 1'b1);
      rdc(rdsr_pkg::ADDR_LEVEL, 32'h0000_0001);
      @(posedge ref_clk);
      srst <= 1'b1;
      @(posedge ref_clk);
      srst <= 1'b0;
      // read data register must be cleared by the reset edge
      @(posedge ref_clk);
      chk(rdat, 32'h0);
      rdc(rdsr_pkg::ADDR_LEVEL, 32'h0);
      rdc(rdsr_pkg::ADDR_CTRL, 32'h0);
      results();
   end
endmodule
